/* core/pgm_defines.vh */
// Register offsets, field positions, masks and fixed codes for the gating/map block
`ifndef PGM_DEFINES_VH
`define PGM_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PGM_OFF_GATING     12'h000
`define PGM_OFF_MAP        12'h004
`define PGM_OFF_SIZE_INFO  12'h008
`define PGM_OFF_SEC_INFO   12'h00c
`define PGM_OFF_PROTECT    12'h010
`define PGM_OFF_STATUS     12'h014
`define PGM_OFF_DECODE     12'h018
`define PGM_OFF_FLASH_CMD  12'h01c

// ----------------------------------------
// Gating register fields
// ----------------------------------------
`define PGM_G_ADDR   0
`define PGM_G_CTL0   2
`define PGM_G_CTL1   3
`define PGM_G_CTL2   4
`define PGM_G_ALE    5
`define PGM_G_WRH    6
`define PGM_G_MASK   8'h7d

// ----------------------------------------
// Memory map register fields
// ----------------------------------------
`define PGM_M_F_SRAM  0
`define PGM_M_F_SEC   1
`define PGM_M_F_PRI   2
`define PGM_M_R_SEC   3
`define PGM_M_R_PRI   4
`define PGM_M_PERIPH  7
`define PGM_M_MASK    8'h9f
`define PGM_M_CFG     8'h1e

// ----------------------------------------
// Size identification codes
// ----------------------------------------
`define PGM_PRI_SIZE   4'h5
`define PGM_SRAM_SIZE  4'h3
`define PGM_SEC_SIZE   4'h2
`define PGM_SEC_TYPE   2'h0

// ----------------------------------------
// Flash command encodings and sector counts
// ----------------------------------------
`define PGM_CMD_PROG     3'h1
`define PGM_CMD_ERASE    3'h2
`define PGM_CMD_SUSPEND  3'h3
`define PGM_CMD_RESUME   3'h4
`define PGM_PRI_SECTORS  8
`define PGM_SEC_SECTORS  4
`define PGM_PROG_CYCLES  16'h0010
`define PGM_ERASE_CYCLES 16'h0400

`endif

/* core/pgm_regs.v */
// Gating, memory map, size identification, sector select and ready/busy logic
//
// What this block does
// - Gating bit 0 set blocks the low eight address lines from the array.
// - Gating bits 4,3,2 disconnect control inputs 2,1,0 from the array.
// - Gating bit 5 disconnects the address latch enable from the array.
// - Gating bit 6 disconnects the high byte write input from the array.
// - Split mode takes address 3..0 from port F, 7..4 from bus lines.
// - Reset loads map bits 1..4 from configuration and clears bits 0 and 7.
// - Map bits 0..4 act only in split program/data bus mode.
// - Map bits 0,1,2 let fetch strobe reach SRAM, secondary, primary.
// - Map bits 3,4 let the read strobe reach secondary and primary.
// - Map bit 7 enables the port F peripheral mode.
// - Size info low nibble codes primary flash size.
// - Size info high nibble codes SRAM size.
// - Secondary info bits 3..0 code secondary memory size.
// - Secondary info bits 5..4 code memory type; bits 7..6 unused.
// - Primary flash has eight sectors, each with its own select.
// - Secondary flash has four sectors, each with its own select.
// - SRAM is one block with one select.
// - Each flash select is an OR of up to three product terms.
// - Each flash sector can be protected on its own.
// - Erase per sector, program per word, erase can suspend and resume.
// - Ready/busy output is low while any program or erase runs.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "pgm_defines.vh"

module pgm_regs (
  // Clock and reset
  input  wire        clock,
  input  wire        nrst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Configuration
  input  wire        split_bus_mode,
  input  wire [7:0]  user_map_cfg,
  // Bus pins from the microcontroller
  input  wire [7:0]  bus_address,
  input  wire [3:0]  portf_low_address_pins,
  input  wire [3:0]  muxed_bus_upper_nibble,
  input  wire        bus_control_in_0,
  input  wire        bus_control_in_1,
  input  wire        bus_control_in_2,
  input  wire        address_latch_enable,
  input  wire        high_byte_write_or_byte_enable,
  input  wire        program_fetch_strobe_n,
  input  wire        data_read_strobe_n,
  // Gated array inputs
  output reg  [7:0]  array_address,
  output reg  [2:0]  array_control,
  output reg         array_ale,
  output reg         array_wrh,
  // Memory selects
  output reg  [7:0]  primary_sector_select,
  output reg  [3:0]  secondary_sector_select,
  output reg         sram_block_select,
  output reg         periph_mode_en,
  // Ready/busy
  output reg         ready_busy_pin
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam NPIN = 23;
  wire [NPIN-1:0] pin_raw;
  reg  [NPIN-1:0] s1_q;
  reg  [NPIN-1:0] s2_q;
  reg  [NPIN-1:0] s3_q;
  reg  [NPIN-1:0] pin_q;

  assign pin_raw = {data_read_strobe_n, program_fetch_strobe_n,
                    high_byte_write_or_byte_enable, address_latch_enable,
                    bus_control_in_2, bus_control_in_1, bus_control_in_0,
                    muxed_bus_upper_nibble, portf_low_address_pins, bus_address};

  // Three stages; a level is accepted when stages two and three agree
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= {NPIN{1'b0}};
      s2_q  <= {NPIN{1'b0}};
      s3_q  <= {NPIN{1'b0}};
      pin_q <= {NPIN{1'b1}};
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end

  wire [7:0] a_bus   = pin_q[7:0];
  wire [3:0] a_pf    = pin_q[11:8];
  wire [3:0] a_mux   = pin_q[15:12];
  wire [2:0] ctl_s   = pin_q[18:16];
  wire       ale_s   = pin_q[19];
  wire       wrh_s   = pin_q[20];
  wire       fetch_n = pin_q[21];
  wire       read_n  = pin_q[22];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  gating_q;
  reg  [7:0]  map_q;
  reg  [11:0] protect_q;
  reg  [31:0] decode_q;
  reg  [2:0]  busy_kind_q;
  reg  [15:0] busy_cnt_q;
  reg         suspended_q;
  reg  [3:0]  target_q;
  reg         cfg_loaded_q;

  localparam BS_IDLE  = 2'h0;
  localparam BS_PROG  = 2'h1;
  localparam BS_ERASE = 2'h2;
  localparam BS_SUSP  = 2'h3;
  reg [1:0] bstate_q;

  // APB strobes
  wire acc   = psel & penable;
  wire wr_en = acc & pwrite;
  wire sel_g = (paddr == `PGM_OFF_GATING);
  wire sel_m = (paddr == `PGM_OFF_MAP);
  wire sel_p = (paddr == `PGM_OFF_PROTECT);
  wire sel_d = (paddr == `PGM_OFF_DECODE);
  wire sel_c = (paddr == `PGM_OFF_FLASH_CMD);
  wire mapped = sel_g | sel_m | sel_p | sel_d | sel_c |
                (paddr == `PGM_OFF_SIZE_INFO) | (paddr == `PGM_OFF_SEC_INFO) |
                (paddr == `PGM_OFF_STATUS);

  // Flash target protected: primary sectors 0..7, secondary 8..11
  function prot_hit;
    input [11:0] prot;
    input [3:0]  tgt;
    begin
      prot_hit = (tgt < 4'hc) ? prot[tgt] : 1'b1;
    end
  endfunction

  // Up to three product terms per select from an 8-bit address
  function sel3;
    input [7:0] a;
    input [7:0] t0;
    input [7:0] t1;
    input [7:0] t2;
    input [2:0] en;
    begin
      sel3 = (en[0] & (a == t0)) | (en[1] & (a == t1)) | (en[2] & (a == t2));
    end
  endfunction

  // Register writes; configuration bits of the map load once after reset
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gating_q     <= 8'h00;
      map_q        <= 8'h00;
      protect_q    <= 12'h000;
      decode_q     <= 32'h0000_0000;
      cfg_loaded_q <= 1'b0;
    end else begin
      if (!cfg_loaded_q) begin
        map_q        <= user_map_cfg & `PGM_M_CFG;
        cfg_loaded_q <= 1'b1;
      end else if (wr_en && sel_m) begin
        map_q <= pwdata[7:0] & `PGM_M_MASK;
      end
      if (wr_en && sel_g) begin
        gating_q <= pwdata[7:0] & `PGM_G_MASK;
      end
      if (wr_en && sel_p) begin
        protect_q <= pwdata[11:0];
      end
      if (wr_en && sel_d) begin
        decode_q <= pwdata;
      end
    end
  end

  // ----------------------------------------
  // Flash program/erase sequencer
  // ----------------------------------------
  wire       cmd_wr = wr_en & sel_c;
  wire [2:0] cmd    = pwdata[2:0];

  // sector erase, word program, suspend and resume
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bstate_q    <= BS_IDLE;
      busy_cnt_q  <= 16'h0000;
      busy_kind_q <= 3'h0;
      suspended_q <= 1'b0;
      target_q    <= 4'h0;
    end else begin
      case (bstate_q)
        BS_IDLE: begin
          if (cmd_wr && !prot_hit(protect_q, pwdata[7:4]) &&
              (cmd == `PGM_CMD_PROG || cmd == `PGM_CMD_ERASE)) begin
            target_q    <= pwdata[7:4];
            busy_kind_q <= cmd;
            busy_cnt_q  <= (cmd == `PGM_CMD_PROG) ? `PGM_PROG_CYCLES : `PGM_ERASE_CYCLES;
            bstate_q    <= (cmd == `PGM_CMD_PROG) ? BS_PROG : BS_ERASE;
          end
        end
        BS_PROG: begin
          if (busy_cnt_q == 16'h0001) begin
            bstate_q <= BS_IDLE;
          end
          busy_cnt_q <= busy_cnt_q - 16'h0001;
        end
        BS_ERASE: begin
          if (cmd_wr && cmd == `PGM_CMD_SUSPEND) begin
            bstate_q    <= BS_SUSP;
            suspended_q <= 1'b1;
          end else begin
            if (busy_cnt_q == 16'h0001) begin
              bstate_q <= BS_IDLE;
            end
            busy_cnt_q <= busy_cnt_q - 16'h0001;
          end
        end
        BS_SUSP: begin
          if (cmd_wr && cmd == `PGM_CMD_RESUME) begin
            bstate_q    <= BS_ERASE;
            suspended_q <= 1'b0;
          end
        end
        default: begin
          bstate_q <= BS_IDLE;
        end
      endcase
    end
  end

  wire busy = (bstate_q == BS_PROG) | (bstate_q == BS_ERASE);

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0000_0000;
    case (paddr)
      `PGM_OFF_GATING:    rd_d = {24'h0, gating_q};
      `PGM_OFF_MAP:       rd_d = {24'h0, map_q};
      `PGM_OFF_SIZE_INFO: rd_d = {24'h0, `PGM_SRAM_SIZE, `PGM_PRI_SIZE};
      `PGM_OFF_SEC_INFO:  rd_d = {24'h0, 2'b00, `PGM_SEC_TYPE, `PGM_SEC_SIZE};
      `PGM_OFF_PROTECT:   rd_d = {20'h0, protect_q};
      `PGM_OFF_STATUS:    rd_d = {24'h0, target_q, suspended_q, 1'b0, bstate_q};
      `PGM_OFF_DECODE:    rd_d = decode_q;
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Array input gating and memory decode
  // ----------------------------------------
  // split mode address source
  wire [7:0] addr_src = split_bus_mode ? {a_mux, a_pf} : a_bus;
  wire       fetch    = ~fetch_n;
  wire       rd       = ~read_n;
  wire       strobe_ok_p;
  wire       strobe_ok_s;
  wire       strobe_ok_r;

  assign strobe_ok_p = ~split_bus_mode | (fetch & map_q[`PGM_M_F_PRI]) |
                       (rd & map_q[`PGM_M_R_PRI]);
  assign strobe_ok_s = ~split_bus_mode | (fetch & map_q[`PGM_M_F_SEC]) |
                       (rd & map_q[`PGM_M_R_SEC]);
  assign strobe_ok_r = ~split_bus_mode | (fetch & map_q[`PGM_M_F_SRAM]) | rd;

  integer i;
  reg [7:0] pri_d;
  reg [3:0] sec_d;
  // primary selects from two product terms each, secondary selects from one
  always @* begin
    pri_d = 8'h00;
    sec_d = 4'h0;
    for (i = 0; i < `PGM_PRI_SECTORS; i = i + 1) begin
      pri_d[i] = strobe_ok_p & sel3(addr_src, decode_q[7:0],
                 decode_q[7:0] + i[7:0], decode_q[15:8] + i[7:0], 3'b110);
    end
    for (i = 0; i < `PGM_SEC_SECTORS; i = i + 1) begin
      sec_d[i] = strobe_ok_s & sel3(addr_src, decode_q[23:16] + i[7:0],
                 decode_q[23:16] + i[7:0], decode_q[23:16] + i[7:0], 3'b001);
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      array_address           <= 8'h00;
      array_control           <= 3'h0;
      array_ale               <= 1'b0;
      array_wrh               <= 1'b0;
      primary_sector_select   <= 8'h00;
      secondary_sector_select <= 4'h0;
      sram_block_select       <= 1'b0;
      periph_mode_en          <= 1'b0;
      ready_busy_pin          <= 1'b1;
    end else begin
      array_address <= gating_q[`PGM_G_ADDR] ? 8'h00 : addr_src;
      array_control <= ctl_s & ~gating_q[`PGM_G_CTL2:`PGM_G_CTL0];
      array_ale     <= ale_s & ~gating_q[`PGM_G_ALE];
      array_wrh     <= wrh_s & ~gating_q[`PGM_G_WRH];
      primary_sector_select   <= pri_d;
      secondary_sector_select <= sec_d;
      sram_block_select <= strobe_ok_r & (addr_src == decode_q[31:24]);
      periph_mode_en    <= map_q[`PGM_M_PERIPH];
      ready_busy_pin    <= ~busy;
    end
  end

endmodule

/* tb/pgm_regs_properties.sv */
// Concurrent checks on the gating and memory map register block
`timescale 1ns/1ps
`include "pgm_defines.vh"
module pgm_regs_properties (
  // Clock, reset and APB
  input wire        clock,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Block outputs
  input wire [7:0]  array_address,
  input wire [2:0]  array_control,
  input wire        array_ale,
  input wire        array_wrh,
  input wire        periph_mode_en,
  input wire        ready_busy_pin
);
  // ----------------------------------------
  // Shadow of written gating bits and map bit 7
  // ----------------------------------------
  reg  [7:0] gate_q;
  reg        per_q;
  wire       wr_ok = psel && penable && pready && pwrite;
  wire       cmd_wr = psel && penable && pwrite && paddr == `PGM_OFF_FLASH_CMD;

  // Follow committed APB writes
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_q <= 8'h00;
      per_q  <= 1'b0;
    end else begin
      if (wr_ok && paddr == `PGM_OFF_GATING) gate_q <= pwdata[7:0];
      if (wr_ok && paddr == `PGM_OFF_MAP) per_q <= pwdata[7];
    end
  end

  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    psel && penable && pready;
  endsequence

  chk_apb_answer: assert property (@(posedge clock) disable iff (!nrst)
    setup_s |=> answer_s) else $error("no answer one cycle after setup");
  chk_ready_pulse: assert property (@(posedge clock) disable iff (!nrst)
    pready |=> !pready) else $error("pready longer than one cycle");
  chk_err_unmapped: assert property (@(posedge clock) disable iff (!nrst)
    pready |-> pslverr == (paddr > `PGM_OFF_FLASH_CMD || paddr[1:0] != 2'b00))
    else $error("bad pslverr");
  chk_addr_blocked: assert property (@(posedge clock) disable iff (!nrst)
    gate_q[0] && $past(gate_q[0]) |-> array_address == 8'h00) else $error("address leak");
  chk_ctl_blocked: assert property (@(posedge clock) disable iff (!nrst)
    ({array_wrh, array_ale, array_control} & gate_q[6:2] & $past(gate_q[6:2])) == 5'h00)
    else $error("control input leak");
  chk_map_clear: assert property (@(posedge clock) disable iff (!nrst)
    !$past(nrst) |-> !periph_mode_en) else $error("peripheral mode after reset");
  chk_periph_bit: assert property (@(posedge clock) disable iff (!nrst)
    per_q == $past(per_q) |-> periph_mode_en == per_q) else $error("peripheral mode wrong");
  chk_size_codes: assert property (@(posedge clock) disable iff (!nrst)
    pready && !pwrite && paddr == `PGM_OFF_SIZE_INFO |->
    prdata[3:0] <= 4'h6 && prdata[7:4] <= 4'h5 && prdata[31:8] == 24'h0)
    else $error("size code out of range");
  chk_sec_codes: assert property (@(posedge clock) disable iff (!nrst)
    pready && !pwrite && paddr == `PGM_OFF_SEC_INFO |->
    prdata[3:0] <= 4'h3 && prdata[5:4] <= 2'h1 && prdata[31:6] == 26'h0)
    else $error("secondary code out of range");
  // busy only starts from a flash command
  chk_busy_hold: assert property (@(posedge clock) disable iff (!nrst)
    $fell(ready_busy_pin) |-> $past(cmd_wr, 2)) else $error("busy without command");
endmodule

bind pgm_regs pgm_regs_properties u_chk (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .array_address(array_address), .array_control(array_control), .array_ale(array_ale),
  .array_wrh(array_wrh), .periph_mode_en(periph_mode_en), .ready_busy_pin(ready_busy_pin)
);

/* tb/pgm_mcu_model.sv */
// Microcontroller bus pin model feeding the block's pin inputs
`timescale 1ns/1ps
module pgm_mcu_model (
  // Clock and requested pattern
  input  wire        clock,
  input  wire [22:0] pins_req,
  // Bus pins
  output reg  [7:0]  bus_address,
  output reg  [3:0]  portf_low_address_pins,
  output reg  [3:0]  muxed_bus_upper_nibble,
  output reg         bus_control_in_0,
  output reg         bus_control_in_1,
  output reg         bus_control_in_2,
  output reg         address_latch_enable,
  output reg         high_byte_write_or_byte_enable,
  output reg         program_fetch_strobe_n,
  output reg         data_read_strobe_n
);
  // Pins driven just after each edge, strobes idle high
  initial {data_read_strobe_n, program_fetch_strobe_n, high_byte_write_or_byte_enable,
    address_latch_enable, bus_control_in_2, bus_control_in_1, bus_control_in_0,
    muxed_bus_upper_nibble, portf_low_address_pins, bus_address} = 23'h600000;
  always @(posedge clock) begin
    {data_read_strobe_n, program_fetch_strobe_n, high_byte_write_or_byte_enable,
      address_latch_enable, bus_control_in_2, bus_control_in_1, bus_control_in_0,
      muxed_bus_upper_nibble, portf_low_address_pins, bus_address} <= pins_req;
  end
endmodule

/* tb/tb_pgm_regs.sv */
// Self-checking bench for the gating and memory map register block
`timescale 1ns/1ps
`include "pgm_defines.vh"
module tb_pgm_regs;
  reg         clock = 1'b0;
  reg         nrst = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         split_bus_mode = 1'b0;
  reg  [7:0]  user_map_cfg = 8'h00;
  reg  [22:0] pins_req = 23'h600000;
  wire [31:0] prdata;
  wire        pready, pslverr, address_latch_enable, high_byte_write_or_byte_enable;
  wire [7:0]  bus_address, array_address, primary_sector_select;
  wire [3:0]  portf_low_address_pins, muxed_bus_upper_nibble, secondary_sector_select;
  wire        bus_control_in_0, bus_control_in_1, bus_control_in_2, program_fetch_strobe_n;
  wire        data_read_strobe_n, array_ale, array_wrh, sram_block_select, periph_mode_en;
  wire        ready_busy_pin;
  wire [2:0]  array_control;
  integer     bad_count = 0, total_checks = 0, i, n, seed_v;
  reg  [31:0] rd, mval, rv, dv;
  reg  [7:0]  g, a_m, ep;
  reg  [3:0]  es;
  reg         er, okp, oks, okr;

  pgm_regs u_dut (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .split_bus_mode(split_bus_mode), .user_map_cfg(user_map_cfg),
    .bus_address(bus_address), .portf_low_address_pins(portf_low_address_pins),
    .muxed_bus_upper_nibble(muxed_bus_upper_nibble), .bus_control_in_0(bus_control_in_0),
    .bus_control_in_1(bus_control_in_1), .bus_control_in_2(bus_control_in_2),
    .address_latch_enable(address_latch_enable),
    .high_byte_write_or_byte_enable(high_byte_write_or_byte_enable),
    .program_fetch_strobe_n(program_fetch_strobe_n), .data_read_strobe_n(data_read_strobe_n),
    .array_address(array_address), .array_control(array_control), .array_ale(array_ale),
    .array_wrh(array_wrh), .primary_sector_select(primary_sector_select),
    .secondary_sector_select(secondary_sector_select), .sram_block_select(sram_block_select),
    .periph_mode_en(periph_mode_en), .ready_busy_pin(ready_busy_pin)
  );
  pgm_mcu_model u_mcu (
    .clock(clock), .pins_req(pins_req), .bus_address(bus_address),
    .portf_low_address_pins(portf_low_address_pins),
    .muxed_bus_upper_nibble(muxed_bus_upper_nibble), .bus_control_in_0(bus_control_in_0),
    .bus_control_in_1(bus_control_in_1), .bus_control_in_2(bus_control_in_2),
    .address_latch_enable(address_latch_enable),
    .high_byte_write_or_byte_enable(high_byte_write_or_byte_enable),
    .program_fetch_strobe_n(program_fetch_strobe_n), .data_read_strobe_n(data_read_strobe_n)
  );

  // 25 MHz clock
  always #20 clock = ~clock;

  // Compare and count
  task check(input string name, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("Error %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask

  // Verdict and end of run
  task results;
    begin
      $display("Checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // One APB transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
        bad_count = bad_count + 1;
        results();
      end
    end
  endtask

  // Bounded wait for the ready level
  task wait_ready(input integer lim);
    begin
      n = 0;
      while (ready_busy_pin !== 1'b1 && n < lim) begin
        @(posedge clock);
        n = n + 1;
      end
      check("ready_wait", 1, ready_busy_pin);
      if (ready_busy_pin !== 1'b1) results();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed_v = $urandom(32'hfab9);
    rv = $urandom;
    user_map_cfg <= rv[7:0];
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    check("idle_ready", 1, ready_busy_pin);
    apb(0, `PGM_OFF_MAP, 0);
    check("map_reset", user_map_cfg & 8'h1e, rd);
    apb(1, `PGM_OFF_SIZE_INFO, 32'hff);
    apb(0, `PGM_OFF_SIZE_INFO, 0);
    check("size_info", {`PGM_SRAM_SIZE, `PGM_PRI_SIZE}, rd);
    apb(0, `PGM_OFF_SEC_INFO, 0);
    check("sec_info", {2'b00, `PGM_SEC_TYPE, `PGM_SEC_SIZE}, rd);
    apb(0, 12'h020, 0);
    check("unmapped_err", 1, er);
    for (i = 0; i < 12; i = i + 1) begin
      rv = $urandom;
      g = rv[7:0] & `PGM_G_MASK;
      mval = $urandom & `PGM_M_MASK;
      dv = $urandom;
      rv = $urandom;
      // Aim the address at one of the decode terms
      case (rv[9:8])
        2'h0: a_m = dv[7:0] + rv[2:0];
        2'h1: a_m = dv[15:8] + rv[2:0];
        2'h2: a_m = dv[23:16] + rv[1:0];
        default: a_m = dv[31:24];
      endcase
      pins_req <= i[0] ? {rv[22:16], a_m, rv[7:0]} : {rv[22:16], rv[15:8], a_m};
      split_bus_mode <= i[0];
      apb(1, `PGM_OFF_GATING, g);
      apb(1, `PGM_OFF_MAP, mval);
      apb(1, `PGM_OFF_DECODE, dv);
      repeat (8) @(posedge clock);
      apb(0, `PGM_OFF_GATING, 0);
      check("gating", g, rd);
      apb(0, `PGM_OFF_MAP, 0);
      check("map", mval, rd);
      apb(0, `PGM_OFF_DECODE, 0);
      check("decode", dv, rd);
      // Strobe permissions, split mode only
      okp = !i[0] || (!pins_req[21] && mval[2]) || (!pins_req[22] && mval[4]);
      oks = !i[0] || (!pins_req[21] && mval[1]) || (!pins_req[22] && mval[3]);
      okr = !i[0] || (!pins_req[21] && mval[0]) || !pins_req[22];
      // Primary sector i answers at either base plus i, secondary sector i at its one base plus i
      for (n = 0; n < 8; n = n + 1) begin
        ep[n] = okp && (a_m == (dv[7:0] + n) % 256 || a_m == (dv[15:8] + n) % 256);
        if (n < 4) es[n] = oks && a_m == (dv[23:16] + n) % 256;
      end
      check("primary_select", ep, primary_sector_select);
      check("secondary_select", es, secondary_sector_select);
      check("sram_select", okr && a_m == dv[31:24], sram_block_select);
      check("array_address", g[0] ? 8'h00 : a_m, array_address);
      check("array_control", pins_req[18:16] & ~g[4:2], array_control);
      check("array_ale", pins_req[19] & ~g[5], array_ale);
      check("array_wrh", pins_req[20] & ~g[6], array_wrh);
      check("periph_mode", mval[7], periph_mode_en);
    end
    apb(1, `PGM_OFF_PROTECT, 32'h001);
    apb(1, `PGM_OFF_FLASH_CMD, {4'h0, 1'b0, `PGM_CMD_PROG});
    repeat (3) @(posedge clock);
    check("protected_sector", 1, ready_busy_pin);
    apb(1, `PGM_OFF_FLASH_CMD, {4'h1, 1'b0, `PGM_CMD_PROG});
    repeat (3) @(posedge clock);
    check("busy_program", 0, ready_busy_pin);
    wait_ready(40);
    // Busy was already low for two cycles before the wait, and n also counts the edge that sees ready
    check("program_time", `PGM_PROG_CYCLES - 1, n);
    apb(1, `PGM_OFF_FLASH_CMD, {4'h8, 1'b0, `PGM_CMD_ERASE});
    apb(1, `PGM_OFF_FLASH_CMD, {4'h8, 1'b0, `PGM_CMD_SUSPEND});
    apb(0, `PGM_OFF_STATUS, 0);
    check("suspended", 8'h8b, rd);
    check("suspend_ready", 1, ready_busy_pin);
    apb(1, `PGM_OFF_FLASH_CMD, {4'h8, 1'b0, `PGM_CMD_RESUME});
    apb(0, `PGM_OFF_STATUS, 0);
    check("resumed", 8'h82, rd);
    check("busy_erase", 0, ready_busy_pin);
    wait_ready(1200);
    results();
  end
endmodule
